// [serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none

module serial_peer #(
    parameter int BIT = 8
) (
    // clock
    input wire logic clk,
    // serial line
    input wire logic txd,
    output logic rxd,
    // handshake
    input wire logic rts,
    output logic cts,
    output logic dsr
);
    int nbits = 8;
    bit par_en = 0;
    bit par_odd = 0;
    bit two_stop = 0;
    bit halted = 0; // sending allowed from reset on
    int bad_cnt = 0;
    logic [7:0] rx_q[$];
    logic [7:0] rd;

    initial begin
        rxd = 1'b1;
        cts = 1'b1;
        dsr = 1'b1;
    end

    function automatic logic par_of(input logic [7:0] d);
        return ^(d & 8'((1 << nbits) - 1)) ^ par_odd;
    endfunction

    task automatic send(input logic [7:0] d, input bit bad_par, input bit bad_stop, input bit obey);
        logic [11:0] bits;
        int n;
        @(posedge clk);
        while (obey && (halted || !rts)) @(posedge clk);
        bits = '1;
        bits[0] = 1'b0;
        for (int i = 0; i < nbits; i++) bits[1 + i] = d[i];
        n = 1 + nbits;
        if (par_en) begin
            bits[n] = par_of(d) ^ bad_par;
            n++;
        end
        bits[n] = !bad_stop;
        n = n + (two_stop ? 2 : 1);
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'b1;
        // idle gap so the receiver can deliver the character
        repeat (2) @(posedge clk);
    endtask

    // receive side: sample at bit centres
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        rd = '0;
        for (int i = 0; i < nbits; i++) begin
            repeat (BIT) @(posedge clk);
            rd[i] = txd;
        end
        if (par_en) begin
            repeat (BIT) @(posedge clk);
            if (txd !== par_of(rd)) bad_cnt++;
        end
        repeat (BIT) @(posedge clk);
        if (txd !== 1'b1) bad_cnt++;
        if (two_stop) begin
            repeat (BIT) @(posedge clk);
            if (txd !== 1'b1) bad_cnt++;
        end
        if (rd == 8'h13) halted = 1'b1;
        if (rd == 8'h11) halted = 1'b0;
        rx_q.push_back(rd);
    end
endmodule

`default_nettype wire

// [serial_port.sv]
`timescale 1ns/1ps
`default_nettype none

module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("char_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (push && !pop) begin
                count <= count + (AW+1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

module serial_port #(
    parameter int DIV_W = serial_port_pkg::DIV_W,
    parameter int FIFO_DEPTH = serial_port_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line
    input wire logic rxd,
    output logic txd,
    // handshake lines, high means on
    input wire logic cts,
    input wire logic dsr,
    output logic rts,
    output logic dtr,
    // service request, one pulse per character with any error
    output logic srq
);
    if (DIV_W < 21 || DIV_W > 32) begin : g_bad_div
        $error("serial_port divisor width must be 21 to 32 bits");
    end

    // pin synchronisers
    logic rx_meta, rx_sync, rx_prev;
    logic cts_meta, cts_sync, dsr_meta, dsr_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
            cts_meta <= 1'b0;
            cts_sync <= 1'b0;
            dsr_meta <= 1'b0;
            dsr_sync <= 1'b0;
        end else begin
            rx_meta <= rxd;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
            cts_meta <= cts;
            cts_sync <= cts_meta;
            dsr_meta <= dsr;
            dsr_sync <= dsr_meta;
        end
    end

    // registers
    logic [6:0] ctrl;
    logic [DIV_W-1:0] divisor;
    logic [7:0] tx_hold;
    logic tx_hold_full;
    logic par_err, frm_err, ovr_err, dev_err;
    logic peer_stop, stop_sent;

    wire [1:0] len_code = ctrl[serial_port_pkg::CTRL_LEN_LSB +: 2];
    wire par_en = ctrl[serial_port_pkg::CTRL_PAR_EN];
    wire par_odd = ctrl[serial_port_pkg::CTRL_PAR_ODD];
    wire two_stop = ctrl[serial_port_pkg::CTRL_TWO_STOP];
    wire hw_flow = ctrl[serial_port_pkg::CTRL_HW_FLOW];
    wire sw_flow = ctrl[serial_port_pkg::CTRL_SW_FLOW];
    wire [2:0] last_bit = {1'b0, len_code} + 3'd4;
    wire [7:0] len_mask = 8'hff >> (3'd7 - last_bit);

    // bus decode
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire wr = access && pwrite;
    wire word = paddr[1:0] == 2'b00;
    wire hit_ctrl = word && paddr == serial_port_pkg::OFS_CTRL;
    wire hit_div = word && paddr == serial_port_pkg::OFS_DIVISOR;
    wire hit_tx = word && paddr == serial_port_pkg::OFS_TXDATA;
    wire hit_rx = word && paddr == serial_port_pkg::OFS_RXDATA;
    wire hit_st = word && paddr == serial_port_pkg::OFS_STATUS;
    wire hit_ev = word && paddr == serial_port_pkg::OFS_EVENT;
    wire mapped = hit_ctrl || hit_div || hit_tx || hit_rx || hit_st || hit_ev;

    // receive fifo
    logic rx_push;
    logic [7:0] rx_char;
    wire rx_in_ready;
    wire rx_out_valid;
    wire [7:0] rx_out_data;
    wire rx_pop = access && !pwrite && hit_rx;

    char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data(rx_char),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_out_data)
    );

    // transmitter
    serial_port_pkg::ser_state_e tx_state;
    logic [DIV_W-1:0] tx_cnt;
    logic [7:0] tx_shift;
    logic [2:0] tx_bit;
    logic tx_par, tx_stop2;

    wire hw_ok = !hw_flow || (cts_sync && dsr_sync);
    wire sw_ok = !sw_flow || !peer_stop;
    wire need_stop = sw_flow && !rx_in_ready && !stop_sent;
    wire need_resume = sw_flow && rx_in_ready && stop_sent;
    wire flow_char = need_stop || need_resume;
    wire tx_idle = tx_state == serial_port_pkg::S_IDLE;
    wire tx_go = tx_idle && hw_ok && (flow_char || (tx_hold_full && sw_ok));
    wire tx_take_hold = tx_go && !flow_char;
    wire [7:0] tx_src = need_stop ? serial_port_pkg::CHAR_STOP :
                        need_resume ? serial_port_pkg::CHAR_RESUME : tx_hold;
    wire [7:0] tx_load = tx_src & len_mask;
    wire tx_tick = !tx_idle && tx_cnt == divisor - DIV_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= serial_port_pkg::S_IDLE;
            tx_cnt <= '0;
            tx_shift <= 8'h00;
            tx_bit <= 3'd0;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
            txd <= 1'b1;
        end else begin
            tx_cnt <= (tx_idle || tx_tick) ? '0 : tx_cnt + DIV_W'(1);
            case (tx_state)
                serial_port_pkg::S_IDLE: begin
                    txd <= 1'b1;
                    if (tx_go) begin
                        tx_shift <= tx_load;
                        tx_par <= (^tx_load) ^ par_odd;
                        tx_bit <= 3'd0;
                        tx_stop2 <= 1'b0;
                        txd <= 1'b0;
                        tx_state <= serial_port_pkg::S_START;
                    end
                end
                serial_port_pkg::S_START: begin
                    if (tx_tick) begin
                        txd <= tx_shift[0];
                        tx_shift <= tx_shift >> 1;
                        tx_state <= serial_port_pkg::S_DATA;
                    end
                end
                serial_port_pkg::S_DATA: begin
                    if (tx_tick) begin
                        if (tx_bit != last_bit) begin
                            txd <= tx_shift[0];
                            tx_shift <= tx_shift >> 1;
                            tx_bit <= tx_bit + 3'd1;
                        end else if (par_en) begin
                            txd <= tx_par;
                            tx_state <= serial_port_pkg::S_PARITY;
                        end else begin
                            txd <= 1'b1;
                            tx_state <= serial_port_pkg::S_STOP;
                        end
                    end
                end
                serial_port_pkg::S_PARITY: begin
                    if (tx_tick) begin
                        txd <= 1'b1;
                        tx_state <= serial_port_pkg::S_STOP;
                    end
                end
                serial_port_pkg::S_STOP: begin
                    if (tx_tick) begin
                        if (two_stop && !tx_stop2) begin
                            tx_stop2 <= 1'b1;
                        end else begin
                            tx_state <= serial_port_pkg::S_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state <= serial_port_pkg::S_IDLE;
                    txd <= 1'b1;
                end
            endcase
        end
    end

    // receiver
    serial_port_pkg::ser_state_e rx_state;
    logic [DIV_W-1:0] rx_cnt;
    logic [2:0] rx_bit;
    logic rx_ones;
    logic rx_done, rx_frm, rx_par;

    wire rx_fall = rx_prev && !rx_sync;
    wire rx_sample = rx_state != serial_port_pkg::S_IDLE && rx_cnt == '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= serial_port_pkg::S_IDLE;
            rx_cnt <= '0;
            rx_bit <= 3'd0;
            rx_ones <= 1'b0;
            rx_char <= 8'h00;
            rx_done <= 1'b0;
            rx_frm <= 1'b0;
            rx_par <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_sample && rx_state != serial_port_pkg::S_IDLE) begin
                rx_cnt <= rx_cnt - DIV_W'(1);
            end else if (rx_sample) begin
                rx_cnt <= divisor - DIV_W'(1);
            end
            case (rx_state)
                serial_port_pkg::S_IDLE: begin
                    if (rx_fall) begin
                        rx_cnt <= divisor >> 1;
                        rx_char <= 8'h00;
                        rx_bit <= 3'd0;
                        rx_ones <= 1'b0;
                        rx_state <= serial_port_pkg::S_START;
                    end
                end
                serial_port_pkg::S_START: begin
                    if (rx_sample) begin
                        rx_state <= rx_sync ? serial_port_pkg::S_IDLE : serial_port_pkg::S_DATA;
                    end
                end
                serial_port_pkg::S_DATA: begin
                    if (rx_sample) begin
                        rx_char[rx_bit] <= rx_sync;
                        rx_ones <= rx_ones ^ rx_sync;
                        rx_bit <= rx_bit + 3'd1;
                        if (rx_bit == last_bit) begin
                            rx_state <= par_en ? serial_port_pkg::S_PARITY : serial_port_pkg::S_STOP;
                        end
                    end
                end
                serial_port_pkg::S_PARITY: begin
                    if (rx_sample) begin
                        rx_ones <= rx_ones ^ rx_sync;
                        rx_state <= serial_port_pkg::S_STOP;
                    end
                end
                serial_port_pkg::S_STOP: begin
                    if (rx_sample) begin
                        rx_frm <= !rx_sync;
                        rx_par <= par_en && (rx_ones != par_odd);
                        rx_done <= 1'b1;
                        rx_state <= serial_port_pkg::S_IDLE;
                    end
                end
                default: begin
                    rx_state <= serial_port_pkg::S_IDLE;
                end
            endcase
        end
    end

    // delivery of a finished character
    wire is_stop_char = rx_char == serial_port_pkg::CHAR_STOP;
    wire is_resume_char = rx_char == serial_port_pkg::CHAR_RESUME;
    wire rx_flow = rx_done && sw_flow && !rx_frm && !rx_par && (is_stop_char || is_resume_char);
    wire rx_keep = rx_done && !rx_flow;
    assign rx_push = rx_keep && rx_in_ready;
    wire ovr_ev = rx_keep && !rx_in_ready;
    wire par_ev = rx_done && rx_par;
    wire frm_ev = rx_done && rx_frm;
    wire any_ev = ovr_ev || par_ev || frm_ev;

    // software-side clears, set wins
    wire st_clr = wr && hit_st;
    wire clr_par = st_clr && pwdata[serial_port_pkg::ST_PAR_ERR];
    wire clr_frm = st_clr && pwdata[serial_port_pkg::ST_FRM_ERR];
    wire clr_ovr = st_clr && pwdata[serial_port_pkg::ST_OVR_ERR];
    wire clr_dev = wr && hit_ev && pwdata[serial_port_pkg::EV_DEV_ERR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_err <= 1'b0;
            frm_err <= 1'b0;
            ovr_err <= 1'b0;
            dev_err <= 1'b0;
            srq <= 1'b0;
            peer_stop <= 1'b0;
            stop_sent <= 1'b0;
        end else begin
            par_err <= (par_err && !clr_par) || par_ev;
            frm_err <= (frm_err && !clr_frm) || frm_ev;
            ovr_err <= (ovr_err && !clr_ovr) || ovr_ev;
            dev_err <= (dev_err && !clr_dev) || any_ev;
            srq <= any_ev;
            if (!sw_flow) begin
                peer_stop <= 1'b0;
            end else if (rx_flow) begin
                peer_stop <= is_stop_char;
            end
            if (!sw_flow) begin
                stop_sent <= 1'b0;
            end else if (tx_go && flow_char) begin
                stop_sent <= need_stop;
            end
        end
    end

    // handshake outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts <= 1'b0;
            dtr <= 1'b0;
        end else begin
            rts <= !hw_flow || rx_in_ready;
            dtr <= 1'b1;
        end
    end

    // read mux
    wire [7:0] status = {stop_sent, ovr_err, frm_err, par_err, peer_stop,
                         !tx_idle, tx_hold_full, rx_out_valid};
    wire [31:0] rd_word =
        hit_ctrl ? {25'h0, ctrl} :
        hit_div ? 32'(divisor) :
        hit_rx ? {24'h0, rx_out_valid ? rx_out_data : 8'h00} :
        hit_st ? {24'h0, status} :
        hit_ev ? {28'h0, dev_err, 3'h0} : 32'h0;

    // bus slave and writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
            ctrl <= serial_port_pkg::CTRL_RESET;
            divisor <= DIV_W'(serial_port_pkg::DIV_RESET);
            tx_hold <= 8'h00;
            tx_hold_full <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rd_word;
            end
            if (wr && hit_ctrl) begin
                ctrl <= pwdata[6:0];
            end
            if (wr && hit_div) begin
                divisor <= pwdata[DIV_W-1:0];
            end
            if (wr && hit_tx && !tx_hold_full) begin
                tx_hold <= pwdata[7:0];
                tx_hold_full <= 1'b1;
            end else if (tx_take_hold) begin
                tx_hold_full <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// [serial_port_pkg.sv]
// What this block does
// - character is low start bit, data, optional parity, one or two high stop bits
// - idle transmitter holds the line high (stop level)
// - receiver realigns its bit timing on every start bit falling edge
// - data field is 5 to 8 bits, least significant bit first
// - transmitter puts parity right after data, giving even or odd ones
// - receiver counts ones over data and parity, flags a mismatch
// - parity, framing or overrun error raises service request and sets event bit 3
// - with hardware handshake, transmit only while all monitored inputs are high
// - software flow control starts in the transmit-permitted state after reset
// - receive buffer full sends stop character; peer's stop character halts our sending
// - buffer room again sends resume character; peer's resume restarts our sending
// - default format is 8 data bits, no parity, one stop bit
// - in 7-bit mode the unused upper received bit reads as zero
// - parity bit and second stop bit can each be enabled
package serial_port_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD_RESET = 9600;
    localparam int DIV_W = 24;
    localparam logic [23:0] DIV_RESET = 24'(CLK_HZ / BAUD_RESET);
    localparam int FIFO_DEPTH = 16;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIVISOR = 8'h04;
    localparam logic [7:0] OFS_TXDATA = 8'h08;
    localparam logic [7:0] OFS_RXDATA = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_EVENT = 8'h14;

    // control fields
    localparam int CTRL_LEN_LSB = 0;
    localparam int CTRL_PAR_EN = 2;
    localparam int CTRL_PAR_ODD = 3;
    localparam int CTRL_TWO_STOP = 4;
    localparam int CTRL_HW_FLOW = 5;
    localparam int CTRL_SW_FLOW = 6;
    localparam logic [6:0] CTRL_RESET = 7'h03;

    // status fields
    localparam int ST_RX_AVAIL = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_PEER_STOP = 3;
    localparam int ST_PAR_ERR = 4;
    localparam int ST_FRM_ERR = 5;
    localparam int ST_OVR_ERR = 6;
    localparam int ST_STOP_SENT = 7;

    localparam int EV_DEV_ERR = 3;

    localparam logic [7:0] CHAR_RESUME = 8'h11;
    localparam logic [7:0] CHAR_STOP = 8'h13;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_START = 3'b001,
        S_DATA = 3'b010,
        S_PARITY = 3'b011,
        S_STOP = 3'b100
    } ser_state_e;
endpackage

// [serial_port_props.sv]
`timescale 1ns/1ps
`default_nettype none

module serial_port_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial line
    input wire logic rxd,
    input wire logic txd,
    // handshake and service request
    input wire logic cts,
    input wire logic dsr,
    input wire logic rts,
    input wire logic dtr,
    input wire logic srq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
    a_unmapped_flag: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
        else $error("unmapped access not flagged");
    a_start_width: assert property ($fell(txd) |-> !txd [*4])
        else $error("start bit too short");
    a_bit_min_width: assert property ($changed(txd) |=> $stable(txd) [*3])
        else $error("serial bit shorter than four cycles");
    a_srq_pulse: assert property (srq |=> !srq)
        else $error("service request longer than one cycle");
    a_dtr_on: assert property ($past(presetn) |-> dtr)
        else $error("terminal ready output low after reset");

    c_srq: cover property (srq);
    c_tx_start: cover property ($fell(txd));
    c_slverr: cover property (pslverr);
endmodule

`default_nettype wire

// [serial_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module serial_port_tb;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic txd;
    logic cts;
    logic dsr;
    logic rts;
    logic dtr;
    logic srq;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    int srq_cnt = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] mask;
    logic [4:0] fmts [5] = '{5'h03, 5'h16, 5'h0c, 5'h05, 5'h1e};

    serial_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rxd, .txd, .cts, .dsr, .rts, .dtr, .srq);
    serial_peer #(.BIT(8)) u_peer (.clk(pclk), .txd, .rxd, .rts, .cts, .dsr);

    task automatic end_of_test();
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) err_total++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    task automatic wait_rx(input int n);
        int t;
        t = 0;
        while (u_peer.rx_q.size() < n && t < 3000) begin
            @(posedge pclk);
            t++;
        end
    endtask

    function automatic logic [31:0] take();
        return u_peer.rx_q.size() ? 32'(u_peer.rx_q.pop_front()) : 32'hx;
    endfunction

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (srq === 1'b1) srq_cnt <= srq_cnt + 1;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_reg(8'h00, 32'h3, "ctrl reset");
        chk_reg(8'h04, {8'h0, serial_port_pkg::DIV_RESET}, "divisor reset");
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
        apb(1'b1, 8'h04, 32'h8);
        chk_reg(8'h04, 32'h8, "divisor");
        // formats: length, parity sense, stop count
        for (int k = 0; k < 5; k++) begin
            u_peer.nbits = 5 + fmts[k][1:0];
            u_peer.par_en = fmts[k][2];
            u_peer.par_odd = fmts[k][3];
            u_peer.two_stop = fmts[k][4];
            mask = 8'((1 << (5 + fmts[k][1:0])) - 1);
            apb(1'b1, 8'h00, {27'h0, fmts[k]});
            apb(1'b1, 8'h08, 32'ha5);
            wait_rx(1);
            check("tx char", take(), {24'h0, 8'ha5 & mask});
            u_peer.send(8'hff, 1'b0, 1'b0, 1'b1);
            chk_reg(8'h0c, {24'h0, mask}, "rx char");
            apb(1'b0, 8'h10, 32'h0);
            check("rx errs", rd & 32'h71, 32'h0);
        end
        // parity then framing error
        u_peer.nbits = 8;
        u_peer.par_odd = 0;
        u_peer.two_stop = 0;
        apb(1'b1, 8'h00, 32'h07);
        u_peer.send(8'h5a, 1'b1, 1'b0, 1'b1);
        chk_reg(8'h10, 32'h11, "parity flag");
        u_peer.send(8'h5a, 1'b0, 1'b1, 1'b1);
        chk_reg(8'h10, 32'h31, "framing flag");
        chk_reg(8'h14, 32'h08, "event bit");
        check("srq pulses", srq_cnt, 32'd2);
        apb(1'b1, 8'h10, 32'h70);
        apb(1'b1, 8'h14, 32'h08);
        apb(1'b0, 8'h0c, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk_reg(8'h10, 32'h0, "flags cleared");
        chk_reg(8'h14, 32'h0, "event cleared");
        // back-to-back characters
        apb(1'b1, 8'h00, 32'h03);
        u_peer.par_en = 0;
        u_peer.nbits = 8;
        u_peer.two_stop = 0;
        u_peer.send(8'h81, 1'b0, 1'b0, 1'b1);
        u_peer.send(8'h7e, 1'b0, 1'b0, 1'b1);
        chk_reg(8'h0c, 32'h81, "first of pair");
        chk_reg(8'h0c, 32'h7e, "second of pair");
        // hardware handshake
        apb(1'b1, 8'h00, 32'h23);
        check("rts room", rts, 32'h1);
        for (int j = 0; j < 2; j++) begin
            if (j == 0) u_peer.cts <= 1'b0;
            else u_peer.dsr <= 1'b0;
            apb(1'b1, 8'h08, 32'h3c + j);
            repeat (200) @(posedge pclk);
            check("held off", u_peer.rx_q.size(), 32'h0);
            u_peer.cts <= 1'b1;
            u_peer.dsr <= 1'b1;
            wait_rx(1);
            check("released", take(), 32'h3c + j);
        end
        // software flow control
        apb(1'b1, 8'h00, 32'h43);
        apb(1'b1, 8'h08, 32'h41);
        wait_rx(1);
        check("xon at start", take(), 32'h41);
        u_peer.send(8'h13, 1'b0, 1'b0, 1'b1);
        chk_reg(8'h10, 32'h08, "peer stopped");
        apb(1'b1, 8'h08, 32'h42);
        repeat (200) @(posedge pclk);
        check("stop obeyed", u_peer.rx_q.size(), 32'h0);
        u_peer.send(8'h11, 1'b0, 1'b0, 1'b1);
        wait_rx(1);
        check("resume obeyed", take(), 32'h42);
        // let the last stop bit finish
        repeat (8) @(posedge pclk);
        chk_reg(8'h10, 32'h0, "flow chars consumed");
        for (int i = 0; i < 17; i++) u_peer.send(8'h20 + 8'(i), 1'b0, 1'b0, i < 16);
        wait_rx(1);
        check("stop char sent", take(), 32'h13);
        apb(1'b0, 8'h10, 32'h0);
        check("full status", rd & 32'hcb, 32'hc1);
        check("overrun srq", srq_cnt, 32'd3);
        apb(1'b1, 8'h00, 32'h63);
        @(posedge pclk);
        check("rts full", rts, 32'h0);
        for (int i = 0; i < 16; i++) chk_reg(8'h0c, 32'h20 + i, "drain");
        apb(1'b0, 8'h10, 32'h0);
        check("drained", rd & 32'h1, 32'h0);
        wait_rx(1);
        check("resume char sent", take(), 32'h11);
        check("peer frame errs", u_peer.bad_cnt, 32'h0);
        end_of_test();
    end
endmodule

bind serial_port serial_port_checker u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .txd, .cts, .dsr, .rts, .dtr, .srq
);

`default_nettype wire
